//--- src/obc_pkg.sv
package obc_pkg;

   // register indices within the control page (one index per 8-bit register)
   localparam logic [6:0] ADDR_DRIVER_CTRL   = 7'h2c;
   localparam logic [6:0] ADDR_RSVD_AFTER    = 7'h2d;
   localparam logic [6:0] ADDR_BIAS_PD       = 7'h2e;
   localparam logic [6:0] ADDR_INPUT_CM      = 7'h32;
   localparam logic [6:0] ADDR_RSVD_TAIL_LO  = 7'h33;
   localparam logic [6:0] ADDR_RSVD_TAIL_HI  = 7'h7f;

   // reset values and the value read from reserved addresses
   localparam logic [7:0] RST_DRIVER_CTRL    = 8'h00;
   localparam logic [7:0] RST_BIAS_PD        = 8'h00;
   localparam logic [7:0] RST_INPUT_CM       = 8'h00;
   localparam logic [7:0] RSVD_READ_VALUE    = 8'h00;

   // driver control fields
   localparam int DEB_MSB      = 7;
   localparam int DEB_LSB      = 5;
   localparam int DAC_BIAS_MSB = 4;
   localparam int DAC_BIAS_LSB = 3;
   localparam int LEFT_MODE    = 2;
   localparam int RIGHT_MODE   = 1;

   // bias and power-down fields
   localparam int PWR_DOWN     = 7;
   localparam int BIAS_FORCE   = 3;
   localparam int BIAS_MSB     = 1;
   localparam int BIAS_LSB     = 0;

   // input common-mode fields
   localparam int ANALOG_INPUT_FIRST_CM      = 7;
   localparam int ANALOG_INPUT_SECOND_CM      = 6;

   // timing
   localparam int CLK_KHZ        = 25000;
   localparam int DEB_MIN_US     = 8;
   localparam int DEB_TICKS      = 8;
   localparam int DEB_BASE_CYC   = (CLK_KHZ * DEB_MIN_US) / (1000 * DEB_TICKS);
   localparam int SETTLE_US      = 100;
   localparam int SETTLE_CYC     = (CLK_KHZ * SETTLE_US + 999) / 1000;

   typedef enum logic [1:0] {
      OBC_DAC_DEFAULT = 2'h0,
      OBC_DAC_RAISED  = 2'h1,
      OBC_DAC_RSVD    = 2'h2,
      OBC_DAC_HIGHEST = 2'h3
   } obc_dac_bias_e;

   typedef enum logic [1:0] {
      OBC_BIAS_OFF    = 2'h0,
      OBC_BIAS_LOW    = 2'h1,
      OBC_BIAS_HIGH   = 2'h2,
      OBC_BIAS_SUPPLY = 2'h3
   } obc_bias_e;

   typedef struct packed {
      logic          left_output_driver_lineout;
      logic          right_output_driver_lineout;
      obc_dac_bias_e dac_bias_mode;
      logic          sw_power_down;
      obc_bias_e     microphone_bias_output;
      logic          analog_input_first_to_cm;
      logic          analog_input_second_to_cm;
   } obc_ctrl_s;

   typedef struct packed {
      logic [6:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } obc_req_s;

endpackage : obc_pkg

//--- src/obc_debounce.sv
`timescale 1ns/1ps
module obc_debounce #(
   parameter int BASE_CYC = obc_pkg::DEB_BASE_CYC,
   parameter int TICKS    = obc_pkg::DEB_TICKS
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [2:0] code,
   input  wire logic       level_in,
   output logic            level_out
);
   localparam int CW = $clog2(BASE_CYC * 64 + 1);
   localparam int TW = $clog2(TICKS + 1);

   // elaboration refuses a divider or tick count that the counters cannot serve
   if (BASE_CYC < 1 || TICKS < 2) begin : g_bad_params
      $error("obc_debounce: bad parameters");
   end

   logic [CW-1:0] div_reg, div_next, period;
   logic [TW-1:0] cnt_reg, cnt_next;
   logic          out_reg, out_next;
   logic          tick;

   // tick period is one eighth of the interval, doubling per code step
   always_comb begin
      period = (code == 3'h0) ? CW'(1) : CW'(BASE_CYC) << (code - 3'h1);
      tick   = (div_reg >= period - CW'(1));
   end

   always_comb begin
      div_next = tick ? '0 : div_reg + CW'(1);
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (code == 3'h0) begin
         out_next = level_in;
         cnt_next = '0;
      end else if (level_in == out_reg) begin
         cnt_next = '0;
      end else if (tick) begin
         if (cnt_reg == TW'(TICKS - 1)) begin
            out_next = level_in;
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + TW'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_reg <= '0;
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign level_out = out_reg;
endmodule : obc_debounce

//--- src/obc_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - debounce code sits in driver control bits 7..5, reset to zero delay.
// - debounce codes map to 0, then 8 us doubling up to 512 us.
// - debounce clock period is interval over eight; eight ticks span one interval.
// - dac bias field decodes default, raised, highest; reserved code never programmed.
// - left output driver is lineout when its bit is one, headphone otherwise.
// - right output driver is lineout when its bit is one, headphone otherwise.
// - top bias-register bit enables software power-down; clear after reset.
// - with detection on and no headset, bias stays off unless forced.
// - bias field selects off, low level, high level or supply tracking.
// - first analog input tied to common mode when its bit is set.
// - second analog input tied to common mode when its bit is set.
// - page defaults valid only after settling interval following any reset.
module obc_regs #(
   parameter int SETTLE_CYC = obc_pkg::SETTLE_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              soft_rst,
   input  wire obc_pkg::obc_req_s req,
   output logic [7:0]             reg_rdata,
   input  wire logic              headset_detect_en,
   input  wire logic              headset_present_pin,
   input  wire logic              short_detect_pin,
   output obc_pkg::obc_ctrl_s     ctrl,
   output logic                   short_detected,
   output logic                   defaults_valid
);
   localparam int SW = $clog2(SETTLE_CYC + 1);

   localparam int NUM_PINS    = 2;
   localparam int PIN_HEADSET = 0;
   localparam int PIN_SHORT   = 1;

   // elaboration refuses a settle count that the counter cannot serve
   if (SETTLE_CYC < 1) begin : g_bad_settle
      $error("obc_regs: SETTLE_CYC must be positive");
   end

   logic [7:0]         drv_reg, drv_next;
   logic [7:0]         bias_reg, bias_next;
   logic [7:0]         cm_reg, cm_next;
   logic [7:0]         rdata_reg, rdata_next;
   logic [SW-1:0]      settle_reg, settle_next;
   logic               valid_reg, valid_next;
   obc_pkg::obc_ctrl_s ctrl_reg, ctrl_next;
   logic [NUM_PINS-1:0] pin_raw, pin_level;
   logic               short_reg;
   logic               deb_out;
   logic               any_rst;

   function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] d,
                                           input logic [7:0] b, input logic [7:0] c);
      unique case (a)
         obc_pkg::ADDR_DRIVER_CTRL: read_mux = d;
         obc_pkg::ADDR_BIAS_PD:     read_mux = b;
         obc_pkg::ADDR_INPUT_CM:    read_mux = c;
         default:                   read_mux = obc_pkg::RSVD_READ_VALUE;
      endcase
   endfunction : read_mux

   // the reserved dac bias code falls back to default current
   function automatic obc_pkg::obc_dac_bias_e dac_decode(input logic [1:0] code);
      unique case (code)
         obc_pkg::OBC_DAC_RAISED:  dac_decode = obc_pkg::OBC_DAC_RAISED;
         obc_pkg::OBC_DAC_HIGHEST: dac_decode = obc_pkg::OBC_DAC_HIGHEST;
         default:                  dac_decode = obc_pkg::OBC_DAC_DEFAULT;
      endcase
   endfunction : dac_decode

   assign any_rst = rst | soft_rst;

   // register writes; reserved addresses ignore writes
   always_comb begin
      drv_next   = drv_reg;
      bias_next  = bias_reg;
      cm_next    = cm_reg;
      if (req.wr) begin
         unique case (req.addr)
            obc_pkg::ADDR_DRIVER_CTRL: drv_next  = req.wdata;
            obc_pkg::ADDR_BIAS_PD:     bias_next = req.wdata;
            obc_pkg::ADDR_INPUT_CM:    cm_next   = req.wdata;
            default:                   drv_next  = drv_reg;
         endcase
      end
   end

   // soft reset clears the registers exactly like hardware reset
   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         drv_reg  <= obc_pkg::RST_DRIVER_CTRL;
         bias_reg <= obc_pkg::RST_BIAS_PD;
         cm_reg   <= obc_pkg::RST_INPUT_CM;
      end else begin
         drv_reg  <= drv_next;
         bias_reg <= bias_next;
         cm_reg   <= cm_next;
      end
   end

   // read data is registered and follows the address one cycle late;
   // soft reset leaves it alone so a read in flight still completes
   always_comb begin
      rdata_next = read_mux(req.addr, drv_reg, bias_reg, cm_reg);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // pin order inside the synchroniser bank
   assign pin_raw[PIN_HEADSET] = headset_present_pin;
   assign pin_raw[PIN_SHORT]   = short_detect_pin;

   // pin inputs: three flops, level moves once stages two and three agree;
   // only hardware reset clears them, so a soft reset cannot fake a pin edge
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin_sync
      logic [2:0] stage_reg, stage_next;
      logic       level_reg, level_next;

      always_comb begin
         stage_next = {stage_reg[1:0], pin_raw[g]};
         level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
      end

      always_ff @(posedge ref_clk) begin
         if (rst) begin
            stage_reg <= '0;
            level_reg <= 1'b0;
         end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
         end
      end

      assign pin_level[g] = level_reg;
   end

   // decoded controls
   always_comb begin
      ctrl_next = ctrl_reg;
      ctrl_next.left_output_driver_lineout  = drv_reg[obc_pkg::LEFT_MODE];
      ctrl_next.right_output_driver_lineout = drv_reg[obc_pkg::RIGHT_MODE];
      ctrl_next.dac_bias_mode = dac_decode(drv_reg[obc_pkg::DAC_BIAS_MSB:obc_pkg::DAC_BIAS_LSB]);
      ctrl_next.sw_power_down = bias_reg[obc_pkg::PWR_DOWN];
      if (headset_detect_en && !pin_level[PIN_HEADSET] && !bias_reg[obc_pkg::BIAS_FORCE]) begin
         ctrl_next.microphone_bias_output = obc_pkg::OBC_BIAS_OFF;
      end else begin
         ctrl_next.microphone_bias_output =
            obc_pkg::obc_bias_e'(bias_reg[obc_pkg::BIAS_MSB:obc_pkg::BIAS_LSB]);
      end
      ctrl_next.analog_input_first_to_cm  = cm_reg[obc_pkg::ANALOG_INPUT_FIRST_CM];
      ctrl_next.analog_input_second_to_cm = cm_reg[obc_pkg::ANALOG_INPUT_SECOND_CM];
   end

   // settling counter restarts on either reset
   always_comb begin
      settle_next = settle_reg;
      valid_next  = valid_reg;
      if (settle_reg == SW'(SETTLE_CYC - 1)) begin
         valid_next = 1'b1;
      end else begin
         settle_next = settle_reg + SW'(1);
      end
   end

   // either reset restarts the count; defaults_valid stays low until it runs out
   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         settle_reg <= '0;
         valid_reg  <= 1'b0;
      end else begin
         settle_reg <= settle_next;
         valid_reg  <= valid_next;
      end
   end

   // decoded controls are registered so every output comes from a flop
   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // short flag follows the debouncer one cycle late; the debouncer takes either reset, so a soft reset also clears it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         short_reg <= 1'b0;
      end else begin
         short_reg <= deb_out;
      end
   end

   obc_debounce #(
      .BASE_CYC (obc_pkg::DEB_BASE_CYC),
      .TICKS    (obc_pkg::DEB_TICKS)
   ) u_debounce (
      .ref_clk   (ref_clk),
      .rst       (any_rst),
      .code      (drv_reg[obc_pkg::DEB_MSB:obc_pkg::DEB_LSB]),
      .level_in  (pin_level[PIN_SHORT]),
      .level_out (deb_out)
   );

   assign reg_rdata      = rdata_reg;
   assign ctrl           = ctrl_reg;
   assign short_detected = short_reg;
   assign defaults_valid = valid_reg;
endmodule : obc_regs

//--- bench/obc_regs_monitor.sv
`timescale 1ns/1ps
module obc_regs_monitor #(
   parameter int SETTLE_CYC = obc_pkg::SETTLE_CYC
) (
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire logic               soft_rst,
   input wire obc_pkg::obc_req_s  req,
   input wire logic [7:0]         reg_rdata,
   input wire logic               headset_detect_en,
   input wire logic               headset_present_pin,
   input wire logic               short_detect_pin,
   input wire obc_pkg::obc_ctrl_s ctrl,
   input wire logic               short_detected,
   input wire logic               defaults_valid
);
   logic [15:0] age_reg, age_next, cnt_reg, cnt_next;
   logic [2:0]  code_reg, code_next;
   logic        pin_reg, any_rst, wr_drv, wr_bias, wr_cm, wr_impl;
   int          per;
   assign any_rst = rst | soft_rst;
   assign wr_drv  = req.wr && req.addr == 7'h2c;
   assign wr_bias = req.wr && req.addr == 7'h2e;
   assign wr_cm   = req.wr && req.addr == 7'h32;
   assign wr_impl = wr_drv || wr_bias || wr_cm;
   assign per     = obc_pkg::DEB_BASE_CYC << (code_reg - 3'h1);
   // age counts cycles since the raw short pin last changed or the driver control register was last written
   always_comb begin
      cnt_next  = cnt_reg + 16'(cnt_reg != 16'hffff);
      code_next = wr_drv ? req.wdata[7:5] : code_reg;
      age_next  = (short_detect_pin != pin_reg || wr_drv) ? 16'h0000 : age_reg + 16'(age_reg != 16'hffff);
      if (any_rst) begin
         cnt_next  = 16'h0000;
         code_next = 3'h0;
         age_next  = 16'h0000;
      end
   end
   always_ff @(posedge ref_clk) begin
      cnt_reg  <= cnt_next;
      code_reg <= code_next;
      age_reg  <= age_next;
      pin_reg  <= short_detect_pin;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (any_rst);
   a_left_mode: assert property (wr_drv |-> ##2 ctrl.left_output_driver_lineout == $past(req.wdata[2], 2))
      else $error("left driver mode wrong");
   a_right_mode: assert property (wr_drv |-> ##2 ctrl.right_output_driver_lineout == $past(req.wdata[1], 2))
      else $error("right driver mode wrong");
   a_dac_decode: assert property (wr_drv |-> ##2 ctrl.dac_bias_mode ==
      ($past(req.wdata[4:3], 2) == 2'h2 ? 2'h0 : $past(req.wdata[4:3], 2)))
      else $error("dac bias decode wrong");
   a_power_down: assert property (wr_bias |-> ##2 ctrl.sw_power_down == $past(req.wdata[7], 2))
      else $error("power down wrong");
   a_bias_forced: assert property (wr_bias && req.wdata[3] |-> ##2
      ctrl.microphone_bias_output == $past(req.wdata[1:0], 2))
      else $error("forced bias wrong");
   a_input_cm: assert property (wr_cm |-> ##2
      {ctrl.analog_input_first_to_cm, ctrl.analog_input_second_to_cm} == $past(req.wdata[7:6], 2))
      else $error("input tie wrong");
   a_read_back: assert property (wr_impl ##1 (!req.wr && req.addr == $past(req.addr)) |=>
      reg_rdata == $past(req.wdata, 2))
      else $error("read back wrong");
   a_rsvd_zero: assert property (req.addr == 7'h2d || req.addr >= 7'h33 |=> reg_rdata == 8'h00)
      else $error("reserved read not zero");
   a_settle_time: assert property (defaults_valid ? cnt_reg >= SETTLE_CYC - 1 : cnt_reg <= SETTLE_CYC + 1)
      else $error("settle timing wrong");
   a_deb_early: assert property (code_reg != 3'h0 && $changed(short_detected) |-> age_reg >= 7 * per)
      else $error("debounce too early");
   a_deb_late: assert property (age_reg >= (code_reg == 3'h0 ? 12 : 9 * per + 12) |->
      short_detected == short_detect_pin)
      else $error("debounce too late");
   c_code_set: cover property (wr_drv && req.wdata[7:5] != 3'h0);
   c_short: cover property ($rose(short_detected));
   c_settled: cover property ($rose(defaults_valid));
endmodule : obc_regs_monitor
bind obc_regs obc_regs_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_obc_regs_monitor (.ref_clk(ref_clk), .rst(rst),
   .soft_rst(soft_rst), .req(req), .reg_rdata(reg_rdata), .headset_detect_en(headset_detect_en),
   .headset_present_pin(headset_present_pin), .short_detect_pin(short_detect_pin), .ctrl(ctrl),
   .short_detected(short_detected), .defaults_valid(defaults_valid));

//--- bench/test_obc_regs.sv
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module test_obc_regs;
   logic               ref_clk = 0, rst = 1, soft_rst = 0, hs_en = 0, hs_in = 0, sc_in = 0, sd, dv;
   obc_pkg::obc_req_s  req = '0;
   obc_pkg::obc_ctrl_s ctrl;
   logic [7:0]         rdata;
   int                 num_errors = 0, total_checks = 0;
   always #20 ref_clk = ~ref_clk;
   obc_regs #(.SETTLE_CYC(8)) u_obc_regs (.ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .req(req),
      .reg_rdata(rdata), .headset_detect_en(hs_en), .headset_present_pin(hs_in), .short_detect_pin(sc_in),
      .ctrl(ctrl), .short_detected(sd), .defaults_valid(dv));
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wr: 1'b1, wdata: d};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      req.addr <= a;
      step(2);
      `CHK(rdata, e)
   endtask : rd
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic t_reset();
      rd(7'h2c, 8'h00);
      rd(7'h2e, 8'h00);
      rd(7'h32, 8'h00);
      `CHK(ctrl, 9'h000)
   endtask : t_reset
   task automatic t_driver();
      for (int i = 0; i < 4; i++) begin
         wr(7'h2c, {3'h0, i[1], i[1] | i[0], i[0], i[1], 1'b0});
         step(2);
         `CHK(ctrl.dac_bias_mode, {i[1], i[1] | i[0]})
         `CHK({ctrl.left_output_driver_lineout, ctrl.right_output_driver_lineout}, {i[0], i[1]})
         rd(7'h2c, {3'h0, i[1], i[1] | i[0], i[0], i[1], 1'b0});
      end
   endtask : t_driver
   task automatic t_bias();
      @(posedge ref_clk);
      hs_en <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(7'h2e, {i[0], 3'h0, i[2], 1'b0, 2'(i)});
         step(2);
         `CHK(ctrl.microphone_bias_output, i[2] ? 2'(i) : 2'h0)
         `CHK(ctrl.sw_power_down, i[0])
      end
      wr(7'h2e, 8'h02);
      @(posedge ref_clk);
      hs_in <= 1'b1;
      step(8);
      `CHK(ctrl.microphone_bias_output, 2'h2)
   endtask : t_bias
   task automatic t_cm();
      for (int i = 0; i < 4; i++) begin
         wr(7'h32, {2'(i), 6'h00});
         step(2);
         `CHK({ctrl.analog_input_first_to_cm, ctrl.analog_input_second_to_cm}, 2'(i))
      end
      rd(7'h2d, 8'h00);
      rd(7'h33, 8'h00);
      rd(7'h32, 8'hc0);
   endtask : t_cm
   task automatic t_short();
      int n = 0;
      wr(7'h2c, 8'h00);
      @(posedge ref_clk);
      sc_in <= 1'b1;
      while (sd !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      `CHK(sd, 1'b1)
      if (n == 20) begin
         report_and_stop();
      end
      // code 1 spans eight ticks of 25 cycles
      wr(7'h2c, 8'h20);
      @(posedge ref_clk);
      sc_in <= 1'b0;
      step(150);
      `CHK(sd, 1'b1)
      step(110);
      `CHK(sd, 1'b0)
   endtask : t_short
   task automatic t_soft();
      @(posedge ref_clk);
      soft_rst <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      soft_rst <= 1'b0;
      step(1);
      `CHK(dv, 1'b0)
      `CHK(ctrl, 9'h000)
      rd(7'h2e, 8'h00);
      step(10);
      `CHK(dv, 1'b1)
   endtask : t_soft
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_driver();
      t_bias();
      t_cm();
      t_short();
      t_soft();
      report_and_stop();
   end
endmodule : test_obc_regs
